// ### hdl/dtp_dual_timer_pwm.sv
// dual 16-bit pwm timer with shared prescaler, dead-zone pairs and a register port.
// assumes a one-cycle strobe master on the same clock; external tick is asynchronous.

module dtp_dual_timer_pwm (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	output logic [31:0] bus_rdata,
	// external tick pin
	input wire logic external_tick_input,
	// pwm outputs, index 0 first timer, 1 second timer
	output logic [1:0] pwm_out,
	output logic [1:0] pwm_out_n,
	// masked timeout levels
	output logic [1:0] expiry_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		dtp_pkg::dtp_regs_t regs;
		dtp_pkg::dtp_timer_t [1:0] tmr;
		dtp_pkg::dtp_dz_t [1:0] dz;
		logic [1:0] raw;
		logic [7:0] pre_cnt;
		logic [3:0] div_cnt;
		logic ext_sync1;
		logic ext_sync2;
		logic ext_prev;
		logic [31:0] rdata;
		logic [1:0] irq;
	} dtp_state_t;

	dtp_state_t st;
	dtp_state_t next_st;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// tick for one timer from its selector; divide codes share one ripple of div_cnt
	function automatic logic sel_tick(input logic [2:0] sel, input logic [3:0] div,
		input logic pre_tick, input logic ext_tick);
		logic t;
		t = 1'b0;
		if (sel[2]) begin
			t = ext_tick;
		end else begin
			case (sel[1:0])
				2'h0: t = pre_tick & (div[0] == 1'b1);
				2'h1: t = pre_tick & (div[1:0] == 2'h3);
				2'h2: t = pre_tick & (div[2:0] == 3'h7);
				2'h3: t = pre_tick & (div == 4'hf);
				default: t = 1'b0;
			endcase
		end
		return t;
	endfunction

	// one timer step; returns the new timer and raises expired on timeout
	function automatic dtp_pkg::dtp_timer_t tmr_step(input dtp_pkg::dtp_timer_t t,
		input logic tick, input logic run, input logic repeat_mode, input logic load,
		input logic [15:0] load_val, input logic [15:0] match_val, output logic expired);
		dtp_pkg::dtp_timer_t n;
		n = t;
		expired = 1'b0;
		if (load) begin
			n.count = load_val;
			n.match = match_val;
			n.level = 1'b0;
			n.done = 1'b0;
		end else if (run && tick && !t.done) begin
			if (t.count == 16'h0000) begin
				expired = 1'b1;
				if (repeat_mode) begin
					n.count = load_val;
					n.match = match_val;
					n.level = 1'b0;
				end else begin
					n.done = 1'b1;
				end
			end else begin
				n.count = t.count - 16'h0001;
				if ((t.count - 16'h0001) == t.match) begin
					n.level = ~t.level;
				end
			end
		end
		return n;
	endfunction

	// complementary pair with both sides low for gap ticks after each edge
	function automatic dtp_pkg::dtp_dz_t dz_step(input dtp_pkg::dtp_dz_t d,
		input logic level, input logic en, input logic [7:0] len, input logic pre_tick);
		dtp_pkg::dtp_dz_t n;
		n = d;
		if (!en) begin
			n.last = level;
			n.gap = 8'h00;
			n.hi = level;
			n.lo = ~level;
		end else if (level != d.last) begin
			n.last = level;
			n.gap = len;
			n.hi = (len == 8'h00) ? level : 1'b0;
			n.lo = (len == 8'h00) ? ~level : 1'b0;
		end else if (d.gap != 8'h00) begin
			if (pre_tick) begin
				n.gap = d.gap - 8'h01;
			end
		end else begin
			n.hi = d.last;
			n.lo = ~d.last;
		end
		return n;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic pre_tick;
		logic ext_tick;
		logic [1:0] tick;
		logic [1:0] load;
		logic [1:0] clr;
		logic [1:0] expired;
		logic [1:0] level;
		logic exp_bit;
		pre_tick = 1'b0;
		ext_tick = 1'b0;
		tick = 2'h0;
		load = 2'h0;
		clr = 2'h0;
		expired = 2'h0;
		level = 2'h0;
		exp_bit = 1'b0;
		next_st = st;

		// external tick: the first stage feeds only the second
		next_st.ext_sync1 = external_tick_input;
		next_st.ext_sync2 = st.ext_sync1;
		next_st.ext_prev = st.ext_sync2;
		ext_tick = st.ext_sync2 & ~st.ext_prev;

		// prescaler ticks every presc+1 clocks
		if (st.pre_cnt >= st.regs.presc) begin
			pre_tick = 1'b1;
			next_st.pre_cnt = 8'h00;
			next_st.div_cnt = st.div_cnt + 4'h1;
		end else begin
			next_st.pre_cnt = st.pre_cnt + 8'h01;
		end
		tick[0] = sel_tick(st.regs.sel[0], st.div_cnt, pre_tick, ext_tick);
		tick[1] = sel_tick(st.regs.sel[1], st.div_cnt, pre_tick, ext_tick);

		// register writes
		if (bus_write) begin
			case (bus_addr)
				dtp_pkg::OFS_CONFIG: begin
					clr[1] = bus_wdata[dtp_pkg::CFG_CLR1_BIT];
					clr[0] = bus_wdata[dtp_pkg::CFG_CLR0_BIT];
					next_st.regs.mask = bus_wdata[dtp_pkg::CFG_MASK_LSB +: 2];
					next_st.regs.sel[1] = bus_wdata[dtp_pkg::CFG_SEL1_LSB +: 3];
					next_st.regs.sel[0] = bus_wdata[dtp_pkg::CFG_SEL0_LSB +: 3];
					next_st.regs.dz_len = bus_wdata[dtp_pkg::CFG_DZLEN_LSB +: 8];
					next_st.regs.presc = bus_wdata[dtp_pkg::CFG_PRESC_LSB +: 8];
				end
				dtp_pkg::OFS_CONTROL: begin
					next_st.regs.repeat_mode[1] = bus_wdata[dtp_pkg::CTL_REPEAT1_BIT];
					next_st.regs.flip[1] = bus_wdata[dtp_pkg::CTL_FLIP1_BIT];
					load[1] = bus_wdata[dtp_pkg::CTL_LOAD1_BIT];
					next_st.regs.run[1] = bus_wdata[dtp_pkg::CTL_RUN1_BIT];
					next_st.regs.dz_en = bus_wdata[dtp_pkg::CTL_DZEN_BIT];
					next_st.regs.repeat_mode[0] = bus_wdata[dtp_pkg::CTL_REPEAT0_BIT];
					next_st.regs.flip[0] = bus_wdata[dtp_pkg::CTL_FLIP0_BIT];
					load[0] = bus_wdata[dtp_pkg::CTL_LOAD0_BIT];
					next_st.regs.run[0] = bus_wdata[dtp_pkg::CTL_RUN0_BIT];
				end
				dtp_pkg::OFS_CMP0: next_st.regs.match_value[0] = bus_wdata[15:0];
				dtp_pkg::OFS_LOAD0: next_st.regs.load_value[0] = bus_wdata[15:0];
				dtp_pkg::OFS_CMP1: next_st.regs.match_value[1] = bus_wdata[15:0];
				dtp_pkg::OFS_LOAD1: next_st.regs.load_value[1] = bus_wdata[15:0];
				default: begin
				end
			endcase
		end

		// timers use the buffers as they stand before this cycle's write
		for (int i = 0; i < 2; i++) begin
			// run gating inside tmr_step
			next_st.tmr[i] = tmr_step(st.tmr[i], tick[i], st.regs.run[i],
				st.regs.repeat_mode[i], load[i], st.regs.load_value[i],
				st.regs.match_value[i], exp_bit);
			expired[i] = exp_bit;
			// a timeout in the clearing cycle survives the clear
			next_st.raw[i] = (st.raw[i] & ~clr[i]) | expired[i];
			level[i] = st.tmr[i].level ^ st.regs.flip[i];
			next_st.dz[i] = dz_step(st.dz[i], level[i], st.regs.dz_en,
				st.regs.dz_len, pre_tick);
		end
		next_st.irq = next_st.raw & ~next_st.regs.mask;

		// register reads, answered in the next cycle
		next_st.rdata = 32'h00000000;
		if (bus_read) begin
			case (bus_addr)
				dtp_pkg::OFS_CONFIG: begin
					next_st.rdata[dtp_pkg::CFG_MASK_LSB +: 2] = st.regs.mask;
					next_st.rdata[dtp_pkg::CFG_SEL1_LSB +: 3] = st.regs.sel[1];
					next_st.rdata[dtp_pkg::CFG_SEL0_LSB +: 3] = st.regs.sel[0];
					next_st.rdata[dtp_pkg::CFG_DZLEN_LSB +: 8] = st.regs.dz_len;
					next_st.rdata[dtp_pkg::CFG_PRESC_LSB +: 8] = st.regs.presc;
				end
				dtp_pkg::OFS_CONTROL: begin
					next_st.rdata[dtp_pkg::CTL_REPEAT1_BIT] = st.regs.repeat_mode[1];
					next_st.rdata[dtp_pkg::CTL_FLIP1_BIT] = st.regs.flip[1];
					next_st.rdata[dtp_pkg::CTL_RUN1_BIT] = st.regs.run[1];
					next_st.rdata[dtp_pkg::CTL_DZEN_BIT] = st.regs.dz_en;
					next_st.rdata[dtp_pkg::CTL_REPEAT0_BIT] = st.regs.repeat_mode[0];
					next_st.rdata[dtp_pkg::CTL_FLIP0_BIT] = st.regs.flip[0];
					next_st.rdata[dtp_pkg::CTL_RUN0_BIT] = st.regs.run[0];
				end
				dtp_pkg::OFS_CMP0: next_st.rdata[15:0] = st.regs.match_value[0];
				dtp_pkg::OFS_LOAD0: next_st.rdata[15:0] = st.regs.load_value[0];
				dtp_pkg::OFS_COUNT0: next_st.rdata[15:0] = st.tmr[0].count;
				dtp_pkg::OFS_CMP1: next_st.rdata[15:0] = st.regs.match_value[1];
				dtp_pkg::OFS_LOAD1: next_st.rdata[15:0] = st.regs.load_value[1];
				dtp_pkg::OFS_COUNT1: next_st.rdata[15:0] = st.tmr[1].count;
				dtp_pkg::OFS_RAW: next_st.rdata[1:0] = st.raw;
				default: next_st.rdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= '0;
			st.regs.mask <= dtp_pkg::MASK_RESET;
			st.dz[0].lo <= 1'b1;
			st.dz[1].lo <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign bus_rdata = st.rdata;
	assign expiry_irq = st.irq;
	assign pwm_out = {st.dz[1].hi, st.dz[0].hi};
	assign pwm_out_n = {st.dz[1].lo, st.dz[0].lo};

endmodule : dtp_dual_timer_pwm

// ### hdl/dtp_pkg.sv
// package of the dual timer pwm block: register map, field positions, reset values, types.
// assumes a single 100 MHz clock and a plain one-cycle strobe register port.
//
// How it works
// - writing one to config bit 25 clears second timeout flag; bit reads zero.
// - writing one to config bit 24 clears first timeout flag; bit reads zero.
// - two mask bits, one per timer, block its interrupt output; both set at reset.
// - second selector codes 000..011 divide by 2,4,8,16; 1xx picks external tick.
// - first selector uses the same encoding in its own field.
// - eight-bit dead-zone length separates complementary output edges when enabled.
// - second repeat bit: zero runs once and stops, one reloads and repeats.
// - second flip bit one inverts the second timer output.
// - writing one to second manual load reloads its counter from load value.
// - second timer counts only while its run bit is one.
// - dead-zone enable bit turns the dead-zone generator on or off.
// - first repeat bit: zero runs once and stops, one reloads and repeats.
// - first flip bit one inverts the first timer output.
// - writing one to first manual load reloads its counter from load value.
// - first timer counts only while its run bit is one.
// - second live count register shows the second timer's present count.
// - raw flag bit one shows second timeout before masking.
// - raw flag bit zero shows first timeout before masking.

package dtp_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_CMP0 = 8'h08;
	localparam logic [7:0] OFS_LOAD0 = 8'h0c;
	localparam logic [7:0] OFS_COUNT0 = 8'h10;
	localparam logic [7:0] OFS_CMP1 = 8'h14;
	localparam logic [7:0] OFS_LOAD1 = 8'h18;
	localparam logic [7:0] OFS_COUNT1 = 8'h1c;
	localparam logic [7:0] OFS_RAW = 8'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_CLR1_BIT = 25;
	localparam int CFG_CLR0_BIT = 24;
	localparam int CFG_MASK_LSB = 22;
	localparam int CFG_SEL1_LSB = 19;
	localparam int CFG_SEL0_LSB = 16;
	localparam int CFG_DZLEN_LSB = 8;
	localparam int CFG_PRESC_LSB = 0;
	localparam int CTL_REPEAT1_BIT = 8;
	localparam int CTL_FLIP1_BIT = 7;
	localparam int CTL_LOAD1_BIT = 6;
	localparam int CTL_RUN1_BIT = 5;
	localparam int CTL_DZEN_BIT = 4;
	localparam int CTL_REPEAT0_BIT = 3;
	localparam int CTL_FLIP0_BIT = 2;
	localparam int CTL_LOAD0_BIT = 1;
	localparam int CTL_RUN0_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MASK_RESET = 2'h3;
	localparam logic [31:0] CONFIG_RESET = 32'h00c00000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] match;
		logic level;
		logic done;
	} dtp_timer_t;

	typedef struct packed {
		logic [7:0] gap;
		logic last;
		logic hi;
		logic lo;
	} dtp_dz_t;

	typedef struct packed {
		logic [1:0] mask;
		logic [1:0][2:0] sel;
		logic [7:0] dz_len;
		logic [7:0] presc;
		logic [1:0] repeat_mode;
		logic [1:0] flip;
		logic [1:0] run;
		logic dz_en;
		logic [1:0][15:0] match_value;
		logic [1:0][15:0] load_value;
	} dtp_regs_t;

endpackage : dtp_pkg

// ### sim/dtp_dual_timer_pwm_tb.sv
// self-checking bench for the dual timer pwm block.
// assumes the design package is compiled first; drives all ports itself.
module dtp_dual_timer_pwm_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] bus_addr = 8'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_write = 1'b0;
	logic bus_read = 1'b0;
	logic external_tick_input = 1'b0;
	logic [31:0] bus_rdata;
	logic [1:0] pwm_out;
	logic [1:0] pwm_out_n;
	logic [1:0] expiry_irq;
	logic [31:0] seed = 32'd96;
	logic [31:0] d;
	logic [31:0] r;
	int n_errors = 0;
	int checks_done = 0;

	always #5 clock = ~clock;

	dtp_dual_timer_pwm dut (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
		.bus_rdata(bus_rdata), .external_tick_input(external_tick_input),
		.pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .expiry_irq(expiry_irq));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= v;
		bus_write <= 1'b1;
		@(posedge clock);
		bus_write <= 1'b0;
	endtask
	task automatic rc(logic [7:0] a, logic [31:0] e);
		@(posedge clock);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clock);
		bus_read <= 1'b0;
		#1 r = bus_rdata;
		chk(r, e);
	endtask
	// read without compare; the caller judges r against a range
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clock);
		bus_read <= 1'b0;
		#1 r = bus_rdata;
	endtask
	task automatic wait_irq(int i);
		int k;
		for (k = 0; k < 400 && expiry_irq[i] !== 1'b1; k++)
			@(posedge clock);
		if (k == 400) begin
			chk(32'h0, 32'h1);
			conclude();
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rc(dtp_pkg::OFS_CONFIG, dtp_pkg::CONFIG_RESET);
		for (int a = 4; a <= 36; a += 4)
			rc(8'(a), 32'h0);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(dtp_pkg::OFS_CMP1, seed);
			rc(dtp_pkg::OFS_CMP1, {16'h0, seed[15:0]});
			wr(dtp_pkg::OFS_LOAD0, seed);
			rc(dtp_pkg::OFS_LOAD0, {16'h0, seed[15:0]});
			wr(dtp_pkg::OFS_CONFIG, seed);
			rc(dtp_pkg::OFS_CONFIG, {8'h0, seed[23:0]});
			wr(dtp_pkg::OFS_RAW, seed);
			rc(dtp_pkg::OFS_RAW, 32'h0);
		end
		$display("registers done");
		wr(dtp_pkg::OFS_CONFIG, 32'h0);
		wr(dtp_pkg::OFS_LOAD0, 32'h5);
		wr(dtp_pkg::OFS_CMP0, 32'h2);
		wr(dtp_pkg::OFS_CONTROL, 32'h2);
		rc(dtp_pkg::OFS_COUNT0, 32'h5);
		wr(dtp_pkg::OFS_CONTROL, 32'h1);
		wait_irq(0);
		rc(dtp_pkg::OFS_RAW, 32'h1);
		repeat (8) @(posedge clock);
		rc(dtp_pkg::OFS_COUNT0, 32'h0);
		wr(dtp_pkg::OFS_CONFIG, 32'h01000000);
		rc(dtp_pkg::OFS_RAW, 32'h0);
		chk(expiry_irq, 2'h0);
		wr(dtp_pkg::OFS_CONTROL, 32'h2);
		wr(dtp_pkg::OFS_CONTROL, 32'h1);
		wr(dtp_pkg::OFS_CONTROL, 32'h0);
		rc(dtp_pkg::OFS_COUNT0, 32'h4);
		repeat (10) @(posedge clock);
		rc(dtp_pkg::OFS_COUNT0, 32'h4);
		$display("one-shot done");
		wr(dtp_pkg::OFS_CONTROL, 32'h84);
		repeat (2) @(posedge clock);
		chk(pwm_out, 2'h3);
		chk(pwm_out_n, 2'h0);
		wr(dtp_pkg::OFS_CONFIG, 32'h00000400);
		wr(dtp_pkg::OFS_CONTROL, 32'h10);
		repeat (2) @(posedge clock);
		chk({pwm_out[0], pwm_out_n[0]}, 2'h0);
		repeat (10) @(posedge clock);
		chk({pwm_out[0], pwm_out_n[0]}, 2'h1);
		$display("outputs done");
		wr(dtp_pkg::OFS_CONTROL, 32'h0);
		wr(dtp_pkg::OFS_CONFIG, 32'h00a00000);
		wr(dtp_pkg::OFS_LOAD1, 32'h2);
		wr(dtp_pkg::OFS_CONTROL, 32'h40);
		wr(dtp_pkg::OFS_CONTROL, 32'h120);
		repeat (4) begin
			repeat (3) @(posedge clock);
			external_tick_input <= 1'b1;
			repeat (3) @(posedge clock);
			external_tick_input <= 1'b0;
		end
		repeat (4) @(posedge clock);
		rc(dtp_pkg::OFS_RAW, 32'h2);
		chk(expiry_irq, 2'h0);
		rc(dtp_pkg::OFS_COUNT1, 32'h1);
		wr(dtp_pkg::OFS_CONTROL, 32'h0);
		wr(dtp_pkg::OFS_CONFIG, 32'h02a00000);
		rc(dtp_pkg::OFS_RAW, 32'h0);
		$display("repeat done");
		wr(dtp_pkg::OFS_CONFIG, 32'h3);
		wr(dtp_pkg::OFS_LOAD0, 32'd20);
		wr(dtp_pkg::OFS_CONTROL, 32'h2);
		wr(dtp_pkg::OFS_CONTROL, 32'h1);
		repeat (40) @(posedge clock);
		wr(dtp_pkg::OFS_CONTROL, 32'h0);
		rd(dtp_pkg::OFS_COUNT0);
		d = r;
		chk(32'(d >= 32'd14 && d <= 32'd16), 32'h1);
		wr(dtp_pkg::OFS_CONTROL, 32'hffffffff);
		rc(dtp_pkg::OFS_CONTROL, 32'h1bd);
		$display("prescaler done");
		conclude();
	end
endmodule // dtp_dual_timer_pwm_tb

bind dtp_dual_timer_pwm dtp_props chk_i (.clock(clock), .sys_rst(sys_rst),
	.bus_addr(bus_addr), .bus_read(bus_read), .bus_rdata(bus_rdata),
	.pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .expiry_irq(expiry_irq));

// ### sim/dtp_props.sv
// checker for the dual timer pwm block, watching its ports only.
// assumes a bind from the bench and one clock with synchronous reset.
module dtp_props (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] bus_addr,
	input wire logic bus_read,
	input wire logic [31:0] bus_rdata,
	// outputs
	input wire logic [1:0] pwm_out,
	input wire logic [1:0] pwm_out_n,
	input wire logic [1:0] expiry_irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_rdata_idle: assert property (!bus_read |=> bus_rdata == 32'h0)
		else $error("read data not zero outside a read slot");
	a_unmapped_zero: assert property (bus_read && (bus_addr > 8'h20 || bus_addr[1:0] != 2'h0)
		|=> bus_rdata == 32'h0) else $error("unmapped read not zero");
	a_reset_outputs: assert property ($fell(sys_rst)
		|-> expiry_irq == 2'h0 && pwm_out == 2'h0 && pwm_out_n == 2'h3)
		else $error("outputs wrong after reset");
	a_pair_exclusive: assert property ((pwm_out & pwm_out_n) == 2'h0)
		else $error("both outputs of a pair high");
	a_raw_upper: assert property (bus_read && bus_addr == dtp_pkg::OFS_RAW
		|=> bus_rdata[31:2] == 30'h0) else $error("raw flags upper bits set");
	a_count_upper: assert property (bus_read
		&& (bus_addr == dtp_pkg::OFS_COUNT0 || bus_addr == dtp_pkg::OFS_COUNT1)
		|=> bus_rdata[31:16] == 16'h0) else $error("count upper bits set");
	a_load_selfclr: assert property (bus_read && bus_addr == dtp_pkg::OFS_CONTROL
		|=> bus_rdata[6] == 1'b0 && bus_rdata[1] == 1'b0 && bus_rdata[31:9] == 23'h0)
		else $error("control load bits read back set");
	a_clear_selfclr: assert property (bus_read && bus_addr == dtp_pkg::OFS_CONFIG
		|=> bus_rdata[31:24] == 8'h0) else $error("config clear bits read back set");
	a_irq_in_raw: assert property (bus_read && bus_addr == dtp_pkg::OFS_RAW
		|=> (bus_rdata[1:0] & $past(expiry_irq)) == $past(expiry_irq))
		else $error("interrupt without raw flag");
endmodule // dtp_props
